// ---- hw/dcp_clock_halver.sv ----
`timescale 1ns/1ps
`default_nettype none

module dcp_clock_halver (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic clockHalvingDisable,
  output logic      canClockEnable
);
  import dcp_pkg::*;

  logic phase_q;
  logic phase_d;

  always_comb begin
    phase_d = ~phase_q;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
    end
  end

  // Enable pulse instead of a derived clock keeps one clock tree.
  assign canClockEnable = clockHalvingDisable | phase_q; // R7 R8

endmodule

`default_nettype wire

// ---- hw/dcp_misc_reg.sv ----
`timescale 1ns/1ps
`default_nettype none

module dcp_misc_reg (
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  input  wire logic                          accessEnable,
  input  wire logic                          busSelect,
  input  wire logic                          busWrite,
  input  wire logic [15:0]                   busAddr,
  input  wire logic [15:0]                   busWriteData,
  output logic      [dcp_pkg::MISC_CONFIG_WIDTH-1:0] miscConfig,
  output logic                               hit
);
  import dcp_pkg::*;

  logic [15:0] config_q;
  logic [15:0] config_d;

  // Writes while access is closed are dropped silently.
  assign hit = busSelect & accessEnable & (busAddr == MISC_CONFIG_ADDR); // R11

  always_comb begin
    config_d = config_q;
    if (hit && busWrite) begin
      config_d = busWriteData & MISC_CONFIG_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      config_q <= MISC_CONFIG_RESET;
    end else begin
      config_q <= config_d;
    end
  end

  assign miscConfig = config_q;

endmodule

`default_nettype wire

// ---- hw/dcp_pin_config.sv ----
// What this block does
// R1: Select 0: second module on port4 bits 4/7, first on bits 5/6.
// R2: Select 1 with both enables: both modules share port4 bits 5/6.
// R3: First module disabled: second stays on bits 4/7 whatever the parallel select.
// R4: Parallel mode feeds both receive inputs from one receive pin.
// R5: Parallel mode transmit pin is AND of both transmit outputs.
// R6: Parallel mode frees port4 bits 4/7 for GPIO or I2C.
// R7: Halving-disable 0 clocks CAN modules at half CPU clock.
// R8: Halving-disable 1 gives CAN modules the undivided CPU clock.
// R9: Analog select 0 converts port5; 1 converts port1, eight channels.
// R10: Regulator-off bit 1 turns regulator off on power-down entry.
// R11: Config register accessible only with both access enables set.
// R12: First line to vector 0 or 3; second to vector 1 or 3.
// R13: Either CAN interrupt wakes interruptible power down without reset.
// R14: Both transmit outputs can be open drain via port4 control.
// R15: Peripheral select bit 0 enables first, bit 1 second module.
// R16: Enabled I2C takes port4 bits 4/7 over the second module.
// R17: Parallel select bit 1, halving-disable bit 2 of config register.
// R18: Parallel condition is select AND both enables, combinational.
`timescale 1ns/1ps
`default_nettype none

module dcp_pin_config (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        busSelect,
  input  wire logic        busWrite,
  input  wire logic [15:0] busAddr,
  input  wire logic [15:0] busWriteData,
  output logic      [15:0] busReadData,
  output logic             busHit,
  input  wire logic [7:0]  peripheralSelect,
  input  wire logic        miscRegisterAccessEnable,
  input  wire logic        busPeripheralEnable,
  input  wire logic        i2cInterfaceEnable,
  input  wire logic [3:0]  port4OpenDrainControl,
  input  wire logic        firstModuleTransmit,
  input  wire logic        secondModuleTransmit,
  output logic             firstModuleReceive,
  output logic             secondModuleReceive,
  output logic             firstModuleEnable,
  output logic             secondModuleEnable,
  output logic             canClockEnable,
  input  wire logic [7:4]  port4In,
  output logic      [7:4]  port4Out,
  output logic      [7:4]  port4Oe,
  output logic      [7:4]  port4CanOwned,
  input  wire logic        firstModuleIrq,
  input  wire logic        secondModuleIrq,
  input  wire logic        firstIrqToShared,
  input  wire logic        secondIrqToShared,
  output logic             busInterruptVector0,
  output logic             busInterruptVector1,
  output logic             busInterruptVector3,
  input  wire logic        interruptiblePowerDown,
  input  wire logic        powerDownEntry,
  output logic             wakeRequest,
  output logic             regulatorOffInSleep,
  output logic             analogInputPortSelect,
  output logic [3:0]       analogChannelLimit
);
  import dcp_pkg::*;

  // ****************************************************************
  // Register access
  // ****************************************************************
  logic [15:0] miscConfig;
  logic        accessOpen;
  logic        regHit;

  assign accessOpen = miscRegisterAccessEnable & busPeripheralEnable; // R11

  dcp_misc_reg u_misc_reg (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .accessEnable (accessOpen),
    .busSelect    (busSelect),
    .busWrite     (busWrite),
    .busAddr      (busAddr),
    .busWriteData (busWriteData),
    .miscConfig   (miscConfig),
    .hit          (regHit)
  );

  logic [15:0] readData_q;
  logic [15:0] readData_d;

  always_comb begin
    readData_d = 16'h0000;
    if (regHit && !busWrite) begin
      readData_d = miscConfig;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      readData_q <= 16'h0000;
    end else begin
      readData_q <= readData_d;
    end
  end

  assign busReadData = readData_q;
  assign busHit      = regHit;

  // ****************************************************************
  // Module enables and clock
  // ****************************************************************
  logic parallelMode;
  logic secondOnUpper;

  assign firstModuleEnable  = peripheralSelect[FIRST_MODULE_EN_BIT]; // R15
  assign secondModuleEnable = peripheralSelect[SECOND_MODULE_EN_BIT]; // R15

  // Parallel mode needs both modules, so a lone second module stays put.
  assign parallelMode = miscConfig[PARALLEL_MAP_SEL_BIT]
                      & firstModuleEnable & secondModuleEnable; // R17 R18 R2 R3
  assign secondOnUpper = secondModuleEnable & ~parallelMode
                       & ~i2cInterfaceEnable; // R1 R3 R6 R16

  dcp_clock_halver u_clock_halver (
    .sys_clk             (sys_clk),
    .reset               (reset),
    .clockHalvingDisable (miscConfig[CLOCK_HALVING_DIS_BIT]), // R17
    .canClockEnable      (canClockEnable)
  );

  // ****************************************************************
  // Pin routing
  // ****************************************************************
  logic sharedTx;
  logic firstTx;

  // A non-transmitting module sits recessive high, so AND lets the other win.
  assign sharedTx = firstModuleTransmit & secondModuleTransmit; // R5
  assign firstTx  = parallelMode ? sharedTx : firstModuleTransmit;

  // Open drain drives only the dominant low and floats the recessive level.
  function automatic logic padEnable(input logic own, input logic od,
                                     input logic val);
    padEnable = own & (~od | ~val);
  endfunction

  always_comb begin
    port4Out      = 4'h0;
    port4CanOwned = 4'h0;
    port4Out[6]      = firstTx; // R1
    port4CanOwned[5] = firstModuleEnable;
    port4CanOwned[6] = firstModuleEnable;
    port4Out[7]      = secondModuleTransmit;
    port4CanOwned[4] = secondOnUpper; // R6
    port4CanOwned[7] = secondOnUpper; // R6
  end

  always_comb begin
    port4Oe    = 4'h0;
    port4Oe[6] = padEnable(port4CanOwned[6], port4OpenDrainControl[2],
                           firstTx); // R14
    port4Oe[7] = padEnable(port4CanOwned[7], port4OpenDrainControl[3],
                           secondModuleTransmit); // R14
  end

  assign firstModuleReceive  = port4In[5];
  // Idle receive is recessive when the second module owns no pin.
  assign secondModuleReceive = parallelMode ? port4In[5] :
                               secondOnUpper ? port4In[4] : 1'b1; // R4

  // ****************************************************************
  // Interrupts and power
  // ****************************************************************
  assign busInterruptVector0 = firstModuleIrq & ~firstIrqToShared; // R12
  assign busInterruptVector1 = secondModuleIrq & ~secondIrqToShared; // R12
  assign busInterruptVector3 = (firstModuleIrq & firstIrqToShared)
                             | (secondModuleIrq & secondIrqToShared); // R12
  assign wakeRequest = interruptiblePowerDown
                     & (firstModuleIrq | secondModuleIrq); // R13

  assign regulatorOffInSleep = powerDownEntry
                             & miscConfig[REGULATOR_OFF_BIT]; // R10
  assign analogInputPortSelect = miscConfig[ANALOG_PORT_SEL_BIT]; // R9
  assign analogChannelLimit = miscConfig[ANALOG_PORT_SEL_BIT]
                            ? 4'(ANALOG_CHANNELS_PORT1) : 4'h0; // R9

endmodule

`default_nettype wire

// ---- hw/dcp_pkg.sv ----
package dcp_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [15:0] MISC_CONFIG_ADDR  = 16'heb46;
  localparam logic [15:0] MISC_CONFIG_RESET = 16'h0000;
  localparam int          MISC_CONFIG_WIDTH = 16;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ANALOG_PORT_SEL_BIT   = 0;
  localparam int PARALLEL_MAP_SEL_BIT  = 1;
  localparam int CLOCK_HALVING_DIS_BIT = 2;
  localparam int REGULATOR_OFF_BIT     = 3;
  localparam logic [15:0] MISC_CONFIG_MASK = 16'h000f;

  // ****************************************************************
  // Peripheral select fields and vectors
  // ****************************************************************
  localparam int FIRST_MODULE_EN_BIT  = 0;
  localparam int SECOND_MODULE_EN_BIT = 1;
  localparam int ANALOG_CHANNELS_PORT1 = 8;

  typedef enum logic [1:0] {
    DCP_VEC_DIRECT = 2'b01,
    DCP_VEC_SHARED = 2'b10
  } dcp_vec_sel_t;

endpackage

// ---- sim/dcp_can_line.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcp_can_line (
  input wire logic [7:4] port4Out, port4Oe,
  input wire logic       domA, domB,
  output logic     [7:4] port4In
);
  // ****************************************************************
  // Wired bus lines
  // ****************************************************************
  // Released pads sit at the external pull-up, so dominant wins.
  logic pad6, pad7;
  assign pad6 = port4Oe[6] ? port4Out[6] : 1'b1;
  assign pad7 = port4Oe[7] ? port4Out[7] : 1'b1;
  assign port4In = {pad7, pad6, pad6 & !domA, pad7 & !domB};
endmodule
`default_nettype wire

// ---- sim/dcp_pin_config_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcp_pin_config_checker (
  input wire logic        sys_clk, reset, busSelect, busWrite, busHit,
  input wire logic        miscRegisterAccessEnable, busPeripheralEnable,
  input wire logic        firstModuleEnable, secondModuleEnable,
  input wire logic        canClockEnable, firstModuleIrq, secondModuleIrq,
  input wire logic        firstIrqToShared, secondIrqToShared,
  input wire logic        busInterruptVector0, busInterruptVector3,
  input wire logic        interruptiblePowerDown, wakeRequest,
  input wire logic        regulatorOffInSleep, powerDownEntry,
  input wire logic        analogInputPortSelect,
  input wire logic [3:0]  analogChannelLimit,
  input wire logic [7:0]  peripheralSelect,
  input wire logic [15:0] busAddr, busWriteData, busReadData
);
  import dcp_pkg::*;
  // ****************************************************************
  // Port relations
  // ****************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_hit_needs_enables: assert property (busHit |-> busSelect &&
    miscRegisterAccessEnable && busPeripheralEnable &&
    busAddr == MISC_CONFIG_ADDR) else $error("hit without access");
  a_refused_reads_zero: assert property (!(busHit && !busWrite) |=>
    busReadData == 16'h0000) else $error("read data without read hit");
  a_write_reads_back: assert property (busHit && busWrite ##1
    !(busHit && busWrite) ##1 busHit && !busWrite |=> busReadData ==
    ($past(busWriteData, 3) & MISC_CONFIG_MASK)) else $error("readback");
  a_enables_follow: assert property (firstModuleEnable ==
    peripheralSelect[0] && secondModuleEnable == peripheralSelect[1])
    else $error("module enable mismatch");
  a_clock_never_stalls: assert property (!canClockEnable |=>
    canClockEnable) else $error("clock enable low twice");
  a_wake_from_irq: assert property (wakeRequest ==
    (interruptiblePowerDown && (firstModuleIrq || secondModuleIrq)))
    else $error("wake request mismatch");
  a_vector_routing: assert property (busInterruptVector0 ==
    (firstModuleIrq && !firstIrqToShared) && busInterruptVector3 ==
    (firstModuleIrq && firstIrqToShared || secondModuleIrq &&
    secondIrqToShared)) else $error("vector routing mismatch");
  a_regulator_gated: assert property (regulatorOffInSleep |->
    powerDownEntry) else $error("regulator off outside power down");
  a_channel_limit: assert property (analogChannelLimit ==
    (analogInputPortSelect ? 4'(ANALOG_CHANNELS_PORT1) : 4'h0))
    else $error("channel limit");
endmodule
bind dcp_pin_config dcp_pin_config_checker u_chk (.*);
`default_nettype wire

// ---- sim/tb_dcp_pin_config.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_dcp_pin_config;
  import dcp_pkg::*;
  logic sys_clk = 0, reset = 1, busSelect = 0, busWrite = 0, busHit;
  logic [15:0] busAddr = 0, busWriteData = 0, busReadData;
  logic [7:0] peripheralSelect = 8'h01;
  logic miscRegisterAccessEnable = 0, busPeripheralEnable = 0;
  logic i2cInterfaceEnable = 0, firstModuleTransmit = 1;
  logic secondModuleTransmit = 1, firstModuleReceive, secondModuleReceive;
  logic firstModuleEnable, secondModuleEnable, canClockEnable;
  logic [3:0] port4OpenDrainControl = 0, analogChannelLimit;
  logic [7:4] port4In, port4Out, port4Oe, port4CanOwned;
  logic firstModuleIrq = 0, secondModuleIrq = 0, firstIrqToShared = 0;
  logic secondIrqToShared = 0, busInterruptVector0, busInterruptVector1;
  logic busInterruptVector3, interruptiblePowerDown = 0;
  logic powerDownEntry = 0, wakeRequest, regulatorOffInSleep;
  logic analogInputPortSelect, domA = 0, domB = 0, pm, on47;
  int errors = 0, tests_run = 0, cycles = 0, n;
  always #5 sys_clk = ~sys_clk;
  dcp_pin_config u_dut (.*);
  dcp_can_line u_line (.*);
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, d);
    @(negedge sys_clk);
    busSelect = 1;
    busWrite = w;
    busAddr = a;
    busWriteData = d;
    @(negedge sys_clk);
    busSelect = 0;
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A hang is cut short well above the expected run of some 140 cycles.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    reset = 0;
    chk(firstModuleEnable, 1);
    acc(1, MISC_CONFIG_ADDR, 16'hffff);
    acc(0, MISC_CONFIG_ADDR, 0);
    chk(busReadData, 0);
    miscRegisterAccessEnable = 1;
    busPeripheralEnable = 1;
    acc(0, MISC_CONFIG_ADDR, 0);
    chk(busReadData, MISC_CONFIG_RESET);
    acc(1, MISC_CONFIG_ADDR, 16'hfff9);
    acc(0, MISC_CONFIG_ADDR + 16'h0002, 0);
    chk(busReadData, 0);
    acc(0, MISC_CONFIG_ADDR, 0);
    chk(busReadData, 16'h0009);
    chk(analogChannelLimit, ANALOG_CHANNELS_PORT1);
    chk(analogInputPortSelect, 1);
    powerDownEntry = 1;
    #1 chk(regulatorOffInSleep, 1);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      acc(1, MISC_CONFIG_ADDR, {13'h0, m[0], 2'b00});
      acc(0, MISC_CONFIG_ADDR, 0);
      chk(busReadData, {13'h0, m[0], 2'b00});
      chk(regulatorOffInSleep, 0);
      chk(analogInputPortSelect, 0);
      n = 0;
      repeat (8) @(negedge sys_clk) n += canClockEnable;
      chk(16'(n), m ? 16'h8 : 16'h4);
    end
    $display("test clock done");
    for (int i = 0; i < 16; i++) begin
      @(negedge sys_clk);
      peripheralSelect = {6'h0, i[1], i[0]};
      i2cInterfaceEnable = i[3];
      acc(1, MISC_CONFIG_ADDR, {13'h0, 1'b1, i[2], 1'b0});
      pm = i[2] & i[0] & i[1];
      on47 = i[1] & !pm & !i[3];
      domA = 1;
      secondModuleTransmit = 0;
      #1 chk(port4In[6], !pm);
      if (i[0]) chk(firstModuleReceive, 0);
      chk(secondModuleReceive, !(pm | on47));
      chk(port4CanOwned, {on47, i[0], i[0], on47});
      @(negedge sys_clk);
      domA = 0;
      domB = 1;
      secondModuleTransmit = 1;
      #1 chk(secondModuleReceive, !on47);
      domB = 0;
    end
    $display("test mapping done");
    peripheralSelect = 8'h01;
    acc(1, MISC_CONFIG_ADDR, 16'h0000);
    port4OpenDrainControl = 4'h4;
    #1 chk(port4Oe[6], 0);
    @(negedge sys_clk);
    firstModuleTransmit = 0;
    #1 chk(port4Oe[6], 1);
    @(negedge sys_clk);
    firstModuleTransmit = 1;
    port4OpenDrainControl = 4'h0;
    #1 chk(port4Oe[6], 1);
    interruptiblePowerDown = 1;
    for (int i = 0; i < 16; i++) begin
      @(negedge sys_clk);
      {secondIrqToShared, firstIrqToShared} = i[3:2];
      {secondModuleIrq, firstModuleIrq} = i[1:0];
      #1 chk({busInterruptVector3, busInterruptVector1, busInterruptVector0},
        {i[0] & i[2] | i[1] & i[3], i[1] & !i[3], i[0] & !i[2]});
      chk(wakeRequest, i[0] | i[1]);
    end
    $display("test interrupts done");
    results();
  end
endmodule
`default_nettype wire
